// ### rtl/pio_defs.svh
`ifndef PIO_DEFS_SVH
`define PIO_DEFS_SVH

// Register byte addresses on the 8-bit bus address
`define PIO_OFF_PS_IN 8'h09
`define PIO_OFF_PS_DIR 8'h0A
`define PIO_OFF_PL_IN 8'h31
`define PIO_OFF_PL_DIR 8'h32
`define PIO_OFF_SLEW 8'h55
// Own registers
`define PIO_OFF_PL_FUNC 8'hE0
`define PIO_OFF_AD_IEN 8'hE4
`define PIO_OFF_AD_POL 8'hE8
`define PIO_OFF_AD_FLAG 8'hEC
`define PIO_OFF_AD_DIEN 8'hF0
`define PIO_OFF_IRQ_STAT 8'hF4
`define PIO_OFF_IRQ_MASK 8'hF8

// Slew select field positions
`define PIO_SLEW_K 7
`define PIO_SLEW_E 4
`define PIO_SLEW_D 3
`define PIO_SLEW_C 2
`define PIO_SLEW_B 1
`define PIO_SLEW_A 0
`define PIO_SLEW_MASK 8'h9F

// Reset values
`define PIO_RST_DIR 8'h00
`define PIO_RST_SLEW 8'h00

// Filter timing
`define PIO_RUN_IGNORE_CLK 3
`define PIO_RUN_ACCEPT_CLK 4
`define PIO_STOP_IGNORE_NS 3200
`define PIO_STOP_ACCEPT_NS 10000
`define PIO_CLK_NS 4
`define PIO_STOP_FILT_CLK ((`PIO_STOP_IGNORE_NS + `PIO_CLK_NS - 1) / `PIO_CLK_NS + 1)

`endif

// ### rtl/pio_pkg.sv
package pio_pkg;
  // Avalon-MM request from the master
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } pio_avreq_t;

  // Peripheral pin functions requesting port S and port L pins
  typedef struct packed {
    logic spiEn;
    logic serialTxSecondEn;
    logic serialRxSecondEn;
    logic serialTxFirstEn;
    logic serialRxFirstEn;
    logic lcdEn;
  } pio_func_t;

  typedef enum logic [1:0] {
    PIO_IDLE,
    PIO_ANSWER
  } pio_bus_state_t;
endpackage

// ### rtl/port_integration_io_control.sv
`timescale 1ns/10ps
`include "pio_defs.svh"
// Functional notes
// - Slew bit 1 limits slew and disables input buffer of that port.
// - Port L input reads 1 when LCD drives pin or buffer disabled.
// - Otherwise port L input reads the synchronised pin level.
// - Writes to port L and port S input registers change nothing.
// - Port L direction: 0 input, 1 output, read and write anytime.
// - LCD-owned port L pin ignores its direction bit.
// - Port S input always returns current port S pin levels.
// - Port S direction: 0 input, 1 output, read and write anytime.
// - SPI enabled takes port S pins 7..4, direction ignored.
// - Second serial tx takes pin 3, rx takes pin 2.
// - First serial tx takes pin 1, rx takes pin 0.
// - Without peripherals, direction bits control port S pins again.
// - Eight analog pins, per-pin enable and edge polarity, one vector.
// - Port interrupt raised when any flag and its enable are set.
// - Pin interrupts work as outputs, or inputs with input enable 1.
// - Enabled pin interrupt produces a wake request in stop and wait.
// - Run filter ignores pulses of 3 clocks, accepts 4 or more.
// - Stop filter ignores pulses to 3.2 us, accepts 10 us or more.
module port_integration_io_control #(
  parameter int STOP_FILT_CLK = `PIO_STOP_FILT_CLK
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Avalon-MM slave
  input wire pio_pkg::pio_avreq_t avReq,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Peripheral pin functions
  input wire pio_pkg::pio_func_t funcEn,
  input wire logic [7:0] spiSerialOut,
  input wire logic [7:0] lcdFrontEn,
  // Port S pins
  input wire logic [7:0] portSPinIn,
  output logic [7:0] portSDirOut,
  // Port L pins
  input wire logic [7:0] portLPinIn,
  output logic [7:0] portLDirOut,
  output logic [7:0] portLLcdSel,
  // Slew and input buffer controls for ports A..E, K
  output logic [7:0] slewSelect,
  // Analog-shared interrupt port
  input wire logic [7:0] adPinIn,
  input wire logic [7:0] adDirOut,
  input wire logic stopMode,
  output logic portIrq,
  output logic wakeReq,
  output logic irq
);
  import pio_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // Pins are asynchronous; only the second stage feeds any logic,
  // so a metastable first stage never reaches a decision
  logic [7:0] psMeta, psSync, plMeta, plSync, adMeta, adSync;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      psMeta <= 8'h00;
      psSync <= 8'h00;
      plMeta <= 8'h00;
      plSync <= 8'h00;
      adMeta <= 8'h00;
      adSync <= 8'h00;
    end
    else
    begin
      psMeta <= portSPinIn;
      psSync <= psMeta;
      plMeta <= portLPinIn;
      plSync <= plMeta;
      adMeta <= adPinIn;
      adSync <= adMeta;
    end
  end

  // ==========================================================
  // Registers
  logic [7:0] portSDirection, portLDirection, slewReg, plDien;
  logic [7:0] adIen, adPol, adFlag, adDien, irqStat, irqMask;
  pio_bus_state_t busState;
  logic wrHit, rdHit;
  logic [7:0] filtEdge;

  // Writes land at the answer edge, while the master still holds its request;
  // reads are latched at the take edge so the data stands when it is sampled
  assign wrHit = avReq.write && (busState == PIO_ANSWER);
  assign rdHit = avReq.read && (busState == PIO_IDLE);

  // Write decode; input registers have no write path
  function automatic logic wrAt(input logic [7:0] off);
    wrAt = wrHit && (avReq.address == off);
  endfunction

  // Read decode, for reads with a side effect
  function automatic logic rdAt(input logic [7:0] off);
    rdAt = rdHit && (avReq.address == off);
  endfunction

  // Port S direction, a plain read-write byte
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portSDirection <= `PIO_RST_DIR;
    else if (wrAt(`PIO_OFF_PS_DIR))
      portSDirection <= avReq.writedata[7:0];
  end

  // Port L direction, a plain read-write byte
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portLDirection <= `PIO_RST_DIR;
    else if (wrAt(`PIO_OFF_PL_DIR))
      portLDirection <= avReq.writedata[7:0];
  end

  // Slew select; spare bits never hold a one
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      slewReg <= `PIO_RST_SLEW;
    else if (wrAt(`PIO_OFF_SLEW))
      slewReg <= avReq.writedata[7:0] & `PIO_SLEW_MASK;
  end

  // Port L input buffer enables; reset leaves buffers off, reads give ones
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      plDien <= 8'h00;
    else if (wrAt(`PIO_OFF_PL_FUNC))
      plDien <= avReq.writedata[7:0];
  end

  // Pin interrupt enables
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      adIen <= 8'h00;
    else if (wrAt(`PIO_OFF_AD_IEN))
      adIen <= avReq.writedata[7:0];
  end

  // Edge polarity select, 1 for rising
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      adPol <= 8'h00;
    else if (wrAt(`PIO_OFF_AD_POL))
      adPol <= avReq.writedata[7:0];
  end

  // Analog pin digital input enables
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      adDien <= 8'h00;
    else if (wrAt(`PIO_OFF_AD_DIEN))
      adDien <= avReq.writedata[7:0];
  end

  // Status mask for the summary interrupt
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irqMask <= 8'h00;
    else if (wrAt(`PIO_OFF_IRQ_MASK))
      irqMask <= avReq.writedata[7:0];
  end

  // Pin flags: write 1 to clear, a new edge wins over the clear
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      adFlag <= 8'h00;
    else if (wrAt(`PIO_OFF_AD_FLAG))
      adFlag <= (adFlag & ~avReq.writedata[7:0]) | filtEdge;
    else
      adFlag <= adFlag | filtEdge;
  end

  // Sticky status: bit0 port irq event, cleared by read; set wins
  // A new event in the reading cycle survives the clear
  logic portIrqRaw, portIrqPrev;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irqStat <= 8'h00;
      portIrqPrev <= 1'b0;
    end
    else
    begin
      portIrqPrev <= portIrqRaw;
      if (rdAt(`PIO_OFF_IRQ_STAT))
        irqStat <= {7'h00, portIrqRaw & ~portIrqPrev};
      else
        irqStat <= irqStat | {7'h00, portIrqRaw & ~portIrqPrev};
    end
  end

  // ==========================================================
  // Bus answer: one wait cycle, then answer
  // Back-to-back requests cost two cycles each; no wait is ever longer
  logic [7:0] portLInput;
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      busState <= PIO_IDLE;
    else
      case (busState)
        PIO_IDLE: if (avReq.read || avReq.write) busState <= PIO_ANSWER;
        PIO_ANSWER: busState <= PIO_IDLE;
        default: busState <= PIO_IDLE;
      endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      waitrequest <= 1'b1;
    else
      waitrequest <= !((avReq.read || avReq.write) && busState == PIO_IDLE);
  end

  // Read mux; unmapped addresses read zero
  // Upper bytes always read zero, the registers are one byte wide
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      readdata <= 32'h0000_0000;
    else if (rdHit)
      case (avReq.address)
        `PIO_OFF_PS_IN: readdata <= {24'h000000, psSync};
        `PIO_OFF_PS_DIR: readdata <= {24'h000000, portSDirection};
        `PIO_OFF_PL_IN: readdata <= {24'h000000, portLInput};
        `PIO_OFF_PL_DIR: readdata <= {24'h000000, portLDirection};
        `PIO_OFF_SLEW: readdata <= {24'h000000, slewReg};
        `PIO_OFF_PL_FUNC: readdata <= {24'h000000, plDien};
        `PIO_OFF_AD_IEN: readdata <= {24'h000000, adIen};
        `PIO_OFF_AD_POL: readdata <= {24'h000000, adPol};
        `PIO_OFF_AD_FLAG: readdata <= {24'h000000, adFlag};
        `PIO_OFF_AD_DIEN: readdata <= {24'h000000, adDien};
        `PIO_OFF_IRQ_STAT: readdata <= {24'h000000, irqStat};
        `PIO_OFF_IRQ_MASK: readdata <= {24'h000000, irqMask};
        default: readdata <= 32'h0000_0000;
      endcase
  end

  // ==========================================================
  // Port L pin ownership and input view
  logic [7:0] lcdOwn;
  assign lcdOwn = lcdFrontEn & {8{funcEn.lcdEn}};
  assign portLInput = (lcdOwn | ~plDien) | plSync;

  // Direction out; an LCD-owned pin drops its direction bit
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portLDirOut <= 8'h00;
    else
      portLDirOut <= portLDirection & ~lcdOwn;
  end

  // LCD ownership out, so the pad switches to the segment signal
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portLLcdSel <= 8'h00;
    else
      portLLcdSel <= lcdOwn;
  end

  // Port S direction, peripherals override; taken pins follow peripheral
  // Taken receive pins are forced to input so a pin never fights the line
  logic [7:0] psTaken, psPeriphDir;
  assign psTaken = {{4{funcEn.spiEn}}, funcEn.serialTxSecondEn, funcEn.serialRxSecondEn,
                    funcEn.serialTxFirstEn, funcEn.serialRxFirstEn};
  assign psPeriphDir = {spiSerialOut[7:4], 1'b1, 1'b0, 1'b1, 1'b0};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portSDirOut <= 8'h00;
    else
      portSDirOut <= (psTaken & psPeriphDir) | (~psTaken & portSDirection);
  end

  // Slew select outputs drive pad slew and input buffer disable
  // Bits 6 and 5 are spare and stay zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      slewSelect <= `PIO_RST_SLEW;
    else
      slewSelect <= slewReg;
  end

  // ==========================================================
  // Pin filters: level must hold this many cycles to be accepted
  logic [7:0] adStable, adSrc;
  logic [15:0] filtCnt [8];
  logic [15:0] filtLimit;
  // Inputs need the input enable; outputs always sense
  assign adSrc = adSync & (adDien | adDirOut);
  // Stop limit is a parameter so the long count can be shortened
  assign filtLimit = stopMode ? 16'(STOP_FILT_CLK) : 16'(`PIO_RUN_ACCEPT_CLK);

  // One counter per pin; a level that flips back restarts the count
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      adStable <= 8'h00;
      filtEdge <= 8'h00;
      for (int i = 0; i < 8; i++)
        filtCnt[i] <= 16'h0000;
    end
    else
      for (int i = 0; i < 8; i++)
      begin
        filtEdge[i] <= 1'b0;
        if (adSrc[i] == adStable[i])
          filtCnt[i] <= 16'h0000;
        else if (filtCnt[i] + 16'h0001 >= filtLimit)
        begin
          // Accepted on the limit-th differing cycle; shorter pulses fall
          // away because the count restarts when the level flips back
          adStable[i] <= adSrc[i];
          filtCnt[i] <= 16'h0000;
          filtEdge[i] <= (adSrc[i] != adPol[i]) ? 1'b0 : 1'b1;
        end
        else
          filtCnt[i] <= filtCnt[i] + 16'h0001;
      end
  end

  // ==========================================================
  // Interrupt outputs
  assign portIrqRaw = |(adFlag & adIen);

  // Port interrupt level, one cycle behind flag and enable
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      portIrq <= 1'b0;
    else
      portIrq <= portIrqRaw;
  end

  // Wake follows the same level, so stop and wait both exit on it
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      wakeReq <= 1'b0;
    else
      wakeReq <= portIrqRaw;
  end

  // Summary interrupt: sticky status under mask
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irqStat & irqMask);
  end

endmodule // port_integration_io_control

// ### sim/pio_properties.sv
`timescale 1ns/10ps
`include "pio_defs.svh"
// ==========
// Port rule checker
module pio_properties #(
  parameter int STOP_FILT_CLK = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Bus and functions
  input wire pio_pkg::pio_avreq_t avReq,
  input wire logic waitrequest,
  input wire pio_pkg::pio_func_t funcEn,
  input wire logic [7:0] spiSerialOut,
  // Watched outputs
  input wire logic [7:0] portSDirOut,
  input wire logic [7:0] portLDirOut,
  input wire logic [7:0] portLLcdSel,
  input wire logic [7:0] slewSelect,
  input wire logic portIrq,
  input wire logic wakeReq
);
  import pio_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_answer_next: assert property (waitrequest && (avReq.read || avReq.write) |=> !waitrequest)
    else $error("no answer after request");
  a_answer_once: assert property (!waitrequest |=> waitrequest)
    else $error("answer held too long");
  a_wake_irq: assert property (wakeReq == portIrq)
    else $error("wake differs from irq");
  a_slew_spare: assert property (slewSelect[6:5] == 2'b00)
    else $error("spare slew bits set");
  // Write lands at the answer edge, the output copy one edge later
  a_slew_write: assert property (waitrequest && avReq.write && avReq.address == `PIO_OFF_SLEW |->
    ##3 slewSelect == ($past(avReq.writedata[7:0], 3) & `PIO_SLEW_MASK))
    else $error("slew copy wrong");
  a_lcd_owns: assert property ((portLLcdSel & portLDirOut) == 8'h00)
    else $error("lcd pin keeps direction");
  a_spi_dir: assert property ($past(funcEn.spiEn) |-> portSDirOut[7:4] == $past(spiSerialOut[7:4]))
    else $error("spi pins not handed over");
  a_tx_out: assert property ($past(funcEn.serialTxSecondEn) |-> portSDirOut[3])
    else $error("tx pin not output");
  a_rx_in: assert property ($past(funcEn.serialRxFirstEn) |-> !portSDirOut[0])
    else $error("rx pin not input");
endmodule // pio_properties
bind port_integration_io_control pio_properties #(.STOP_FILT_CLK(STOP_FILT_CLK)) chk (
  .ref_clk(ref_clk), .rstn(rstn), .avReq(avReq), .waitrequest(waitrequest), .funcEn(funcEn),
  .spiSerialOut(spiSerialOut), .portSDirOut(portSDirOut), .portLDirOut(portLDirOut),
  .portLLcdSel(portLLcdSel), .slewSelect(slewSelect), .portIrq(portIrq), .wakeReq(wakeReq));

// ### sim/pio_pin_model.sv
`timescale 1ns/10ps
// ==========
// External pin drivers
module pio_pin_model (
  // Clock
  input wire logic ref_clk,
  // Pin levels
  output logic [7:0] portSPinIn,
  output logic [7:0] portLPinIn,
  output logic [7:0] adPinIn
);
  // Pins start low; no pull to fall back on
  initial
  begin
    portSPinIn = 8'h00;
    portLPinIn = 8'h00;
    adPinIn = 8'h00;
  end
  // Static levels on ports S and L
  task automatic drive(input logic [7:0] s, input logic [7:0] l);
    @(posedge ref_clk);
    portSPinIn <= s;
    portLPinIn <= l;
  endtask
  // High pulse of n clocks on analog pin 0
  task automatic pulse(input int n);
    @(posedge ref_clk);
    adPinIn[0] <= 1'b1;
    repeat (n) @(posedge ref_clk);
    adPinIn[0] <= 1'b0;
  endtask
endmodule // pio_pin_model

// ### sim/tb.sv
`timescale 1ns/10ps
`include "pio_defs.svh"
module tb;
  import pio_pkg::*;
  logic ref_clk, rstn, waitrequest, stopMode, portIrq, wakeReq, irq;
  pio_avreq_t avReq;
  pio_func_t funcEn;
  logic [31:0] readdata, seed;
  logic [7:0] spiSerialOut, lcdFrontEn, portSPinIn, portSDirOut, portLPinIn, portLDirOut;
  logic [7:0] portLLcdSel, slewSelect, adPinIn, adDirOut, v, d, e;
  logic [7:0] expQ[$];
  int badCount = 0;
  int samplesChecked = 0;
  port_integration_io_control #(.STOP_FILT_CLK(8)) uut (.ref_clk(ref_clk), .rstn(rstn),
    .avReq(avReq), .readdata(readdata), .waitrequest(waitrequest), .funcEn(funcEn),
    .spiSerialOut(spiSerialOut), .lcdFrontEn(lcdFrontEn), .portSPinIn(portSPinIn),
    .portSDirOut(portSDirOut), .portLPinIn(portLPinIn), .portLDirOut(portLDirOut),
    .portLLcdSel(portLLcdSel), .slewSelect(slewSelect), .adPinIn(adPinIn), .adDirOut(adDirOut),
    .stopMode(stopMode), .portIrq(portIrq), .wakeReq(wakeReq), .irq(irq));
  pio_pin_model pm (.ref_clk(ref_clk), .portSPinIn(portSPinIn), .portLPinIn(portLPinIn),
    .adPinIn(adPinIn));
  // ==========
  // Helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic chk(input string n, input logic [7:0] ex, input logic [7:0] got);
    samplesChecked++;
    if (got !== ex)
    begin
      $display("BAD %s expected %h seen %h", n, ex, got);
      badCount++;
    end
  endtask
  // Hold request until waitrequest low is seen at an edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] dt);
    int n = 0;
    @(posedge ref_clk);
    avReq <= '{a, !w, w, dt};
    do @(posedge ref_clk); while (waitrequest !== 1'b0 && ++n < 20);
    if (n >= 20)
    begin
      badCount++;
      printVerdict();
    end
    avReq.read <= 1'b0;
    avReq.write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex);
    expQ.push_back(ex);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] dt);
    bus(a, 1'b1, {24'h0, dt});
  endtask
  // Sync plus filter plus register latency
  task automatic settle();
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic printVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Read answers compared in order of issue
  always @(posedge ref_clk)
    if (rstn && waitrequest === 1'b0 && avReq.read === 1'b1)
    begin
      chk("readdata", expQ.pop_front(), readdata[7:0]);
      chk("readdataUpper", 8'h00, readdata[31:24] | readdata[23:16] | readdata[15:8]);
    end
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the expected run
  initial
  begin
    #80000;
    badCount++;
    printVerdict();
  end
  // ==========
  // Main sequence
  initial
  begin
    {avReq, funcEn, spiSerialOut, lcdFrontEn, adDirOut, stopMode, rstn} = '0;
    seed = 32'h0000000F;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`PIO_OFF_PS_DIR, 8'h00);
    rd(`PIO_OFF_PL_DIR, 8'h00);
    rd(8'h10, 8'h00);
    v = rnd();
    wr(`PIO_OFF_SLEW, v);
    rd(`PIO_OFF_SLEW, v & 8'h9F);
    settle();
    chk("slewSelect", v & 8'h9F, slewSelect);
    $display("slew test done");
    d = rnd();
    v = rnd();
    wr(`PIO_OFF_PS_DIR, d);
    spiSerialOut <= v;
    for (int k = 0; k < 6; k++)
    begin
      e = d;
      case (k)
        1: e[0] = 1'b0;
        2: e[1] = 1'b1;
        3: e[2] = 1'b0;
        4: e[3] = 1'b1;
        5: e[7:4] = v[7:4];
        default: ;
      endcase
      funcEn <= pio_func_t'(6'(1 << k));
      settle();
      chk("portSDirOut", e, portSDirOut);
      @(posedge ref_clk);
    end
    funcEn <= '0;
    settle();
    chk("portSDirOut", d, portSDirOut);
    v = rnd();
    pm.drive(v, ~v);
    settle();
    rd(`PIO_OFF_PS_IN, v);
    wr(`PIO_OFF_PS_IN, 8'h5A);
    rd(`PIO_OFF_PS_IN, v);
    rd(`PIO_OFF_PS_DIR, d);
    $display("port S test done");
    d = rnd();
    wr(`PIO_OFF_PL_DIR, d);
    rd(`PIO_OFF_PL_DIR, d);
    rd(`PIO_OFF_PL_IN, 8'hFF);
    wr(`PIO_OFF_PL_FUNC, 8'hFF);
    rd(`PIO_OFF_PL_IN, ~v);
    e = rnd();
    lcdFrontEn <= e;
    funcEn.lcdEn <= 1'b1;
    settle();
    rd(`PIO_OFF_PL_IN, ~v | e);
    chk("portLLcdSel", e, portLLcdSel);
    chk("portLDirOut", d & ~e, portLDirOut);
    wr(`PIO_OFF_PL_IN, 8'h00);
    rd(`PIO_OFF_PL_IN, ~v | e);
    rd(`PIO_OFF_PL_DIR, d);
    $display("port L test done");
    wr(`PIO_OFF_AD_IEN, 8'h01);
    wr(`PIO_OFF_AD_POL, 8'h01);
    wr(`PIO_OFF_AD_DIEN, 8'h01);
    wr(`PIO_OFF_IRQ_MASK, 8'h01);
    pm.pulse(3);
    settle();
    rd(`PIO_OFF_AD_FLAG, 8'h00);
    pm.pulse(4);
    settle();
    chk("portIrq", 8'h01, {7'h0, portIrq});
    chk("irq", 8'h01, {7'h0, irq});
    rd(`PIO_OFF_AD_FLAG, 8'h01);
    rd(`PIO_OFF_IRQ_STAT, 8'h01);
    settle();
    chk("irq", 8'h00, {7'h0, irq});
    wr(`PIO_OFF_AD_FLAG, 8'h01);
    settle();
    chk("portIrq", 8'h00, {7'h0, portIrq});
    adDirOut <= rnd() & 8'hFE;
    wr(`PIO_OFF_AD_DIEN, 8'h00);
    pm.pulse(6);
    settle();
    rd(`PIO_OFF_AD_FLAG, 8'h00);
    adDirOut <= adDirOut | 8'h01;
    pm.pulse(6);
    settle();
    rd(`PIO_OFF_AD_FLAG, 8'h01);
    wr(`PIO_OFF_AD_FLAG, 8'h01);
    stopMode <= 1'b1;
    pm.pulse(5);
    settle();
    rd(`PIO_OFF_AD_FLAG, 8'h00);
    pm.pulse(12);
    settle();
    rd(`PIO_OFF_AD_FLAG, 8'h01);
    chk("wakeReq", 8'h01, {7'h0, wakeReq});
    $display("interrupt test done");
    // Reset in mid-run: flags, directions and outputs go back to reset values
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    chk("wakeReq", 8'h00, {7'h0, wakeReq});
    chk("portSDirOut", 8'h00, portSDirOut);
    rd(`PIO_OFF_AD_FLAG, 8'h00);
    rd(`PIO_OFF_PL_DIR, 8'h00);
    v = rnd();
    stopMode <= v[0];
    $display("reset test done");
    printVerdict();
  end
endmodule // tb
